// *** shared/bcs_cfg.svh ***
// Offsets, reset values, bit positions and timing figures of the board control and status registers
`ifndef BCS_CFG_SVH
`define BCS_CFG_SVH

// Register offsets on the serial port
`define BCS_ADDR_GPI_HIGH   7'h07
`define BCS_ADDR_INDICATOR  7'h08
`define BCS_ADDR_MGMT       7'h09
`define BCS_ADDR_PHY        7'h0A
`define BCS_ADDR_BUTTON     7'h0B

// Reset values
`define BCS_IND_RESET       8'h00
`define BCS_PHY_RESET       8'h03
`define BCS_ZERO_BYTE       8'h00

// Field positions
`define BCS_PHY_RESET_BIT   1
`define BCS_IND_WIDTH       4
`define BCS_CMD_READ_BIT    7

// Serial frame: command byte then data byte
`define BCS_CMD_LAST_BIT    5'h07
`define BCS_DATA_LAST_BIT   5'h0F
`define BCS_FRAME_BITS      5'h10

// Positions in the synchronised input vector
`define BCS_SI_GPI_LO       0
`define BCS_SI_GPI_HI       7
`define BCS_SI_CHASSIS      8
`define BCS_SI_HOST_RST     9
`define BCS_SI_POR_REQ      10
`define BCS_SI_WARM_REQ     11
`define BCS_SI_BOOT_DONE    12
`define BCS_SI_PHY_INTERRUPT_N      13
`define BCS_SI_FULL_BTN     14
`define BCS_SI_WARM_BTN     15
`define BCS_SI_BUTTON_A     16
`define BCS_SI_TEST_RST     17
`define BCS_SI_SCLK         18
`define BCS_SI_CS_N         19
`define BCS_SI_MOSI         20
`define BCS_SI_WIDTH        21

// Timing
`define BCS_CLK_PERIOD_NS   50
`define BCS_SEQ_DELAY_NS    100000
`define BCS_SEQ_PULSE_NS    10000
`define BCS_SEQ_DELAY_CYC   ((`BCS_SEQ_DELAY_NS + `BCS_CLK_PERIOD_NS - 1) / `BCS_CLK_PERIOD_NS)
`define BCS_SEQ_PULSE_CYC   ((`BCS_SEQ_PULSE_NS + `BCS_CLK_PERIOD_NS - 1) / `BCS_CLK_PERIOD_NS)
`define BCS_UP_SETTLED      3'h4

`endif

// *** shared/bcs_pkg.sv ***
// Types shared by the board control and status register block
package bcs_pkg;

    typedef enum logic [1:0] {
        BCS_SEQ_IDLE,
        BCS_SEQ_WAIT,
        BCS_SEQ_ASSERT
    } bcs_seq_t;

    typedef enum logic {
        BCS_KIND_FULL,
        BCS_KIND_WARM
    } bcs_kind_t;

endpackage : bcs_pkg

// *** core/bcs_regs.sv ***
// Board control and status registers 07h to 0Bh behind a sampled serial port, with reset sequencing
// Overview of operation
// RL1: Offset 07h returns live processor inputs 8 to 15; writes ignored.
// RL2: Indicator bits 0 to 3 drive debug outputs; 0 lights, 1 darkens.
// RL3: Indicator register resets to zero, all indicators lit.
// RL4: Management status bit 0 reports chassis detect; register read-only.
// RL5: Bit 1 reports host reset status, forwarded unchanged to management.
// RL6: Bit 2 reports power-on request; low starts full sequence, high idles.
// RL7: Bit 3 reports warm request; low starts warm sequence, high idles.
// RL8: Bit 4 reports boot done, forwarded unchanged to management.
// RL9: PHY bit 0 read-only, reports interrupt pin level.
// RL10: PHY bit 1 writable, drives PHY reset; resets high.
// RL11: Button bit 0 reports full button; rising edge runs delayed full reset.
// RL12: Button bit 1 reports warm button; rising edge runs delayed warm reset.
// RL13: Button bit 2 reports button_a only; no reset action.
// RL14: Button bit 3 reports test-port reset level.
// RL15: Reserved read-only bits read zero and ignore writes.
`timescale 1ns/1ps
`include "bcs_cfg.svh"

module bcs_regs #(
    parameter int SEQ_DELAY_CYC = `BCS_SEQ_DELAY_CYC,
    parameter int SEQ_PULSE_CYC = `BCS_SEQ_PULSE_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Serial register port
    input  wire logic       spi_clk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    // Processor side
    input  wire logic [7:0] host_gpi_high,
    input  wire logic       host_reset_status,
    input  wire logic       host_boot_done,
    output logic            host_full_reset_n,
    output logic            host_warm_reset_n,
    // Management controller side
    input  wire logic       mgmt_chassis_detect_n,
    input  wire logic       mgmt_power_on_request_n,
    input  wire logic       mgmt_warm_reset_request_n,
    output logic            mgmt_reset_status_out_n,
    output logic            mgmt_boot_complete_out,
    // PHY
    input  wire logic       phy_interrupt_n,
    output logic            phy_reset_out,
    // Buttons and test port
    input  wire logic       full_reset_button,
    input  wire logic       warm_reset_button,
    input  wire logic       button_a,
    input  wire logic       test_port_reset_n,
    // Indicators
    output logic [3:0]      debug_indicator_out
);
    import bcs_pkg::*;

    logic [`BCS_SI_WIDTH-1:0] sync1_ff;
    logic [`BCS_SI_WIDTH-1:0] sync2_ff;
    logic [`BCS_SI_WIDTH-1:0] prev_ff;
    logic [`BCS_SI_WIDTH-1:0] pins;
    logic [7:0]               ind_ff;
    logic [7:0]               phy_ff;
    logic [7:0]               shift_ff;
    logic [7:0]               cmd_ff;
    logic [7:0]               tx_ff;
    logic [4:0]               bit_cnt_ff;
    logic                     wr_stb_ff;
    logic [6:0]               wr_addr_ff;
    logic [7:0]               wr_data_ff;
    logic                     spi_miso_ff;
    logic                     mgmt_rst_ff;
    logic                     mgmt_boot_ff;
    bcs_seq_t                 seq_ff;
    bcs_kind_t                kind_ff;
    logic [15:0]              seq_cnt_ff;
    logic                     full_n_ff;
    logic                     warm_n_ff;
    logic [2:0]               up_cnt_ff;
    logic                     sclk_rise;
    logic                     sclk_fall;
    logic                     cs_act;
    logic [7:0]               in_byte;
    logic [7:0]               rd_data;
    logic                     full_trig;
    logic                     warm_trig;

    assign pins = {spi_mosi, spi_cs_n, spi_clk, test_port_reset_n, button_a, warm_reset_button,
                   full_reset_button, phy_interrupt_n, host_boot_done, mgmt_warm_reset_request_n,
                   mgmt_power_on_request_n, host_reset_status, mgmt_chassis_detect_n, host_gpi_high};

    // Two-stage synchroniser for every pin, then one more stage for edge finding
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end else begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign sclk_rise = sync2_ff[`BCS_SI_SCLK] & ~prev_ff[`BCS_SI_SCLK];
    assign sclk_fall = ~sync2_ff[`BCS_SI_SCLK] & prev_ff[`BCS_SI_SCLK];
    assign cs_act    = ~sync2_ff[`BCS_SI_CS_N];
    assign in_byte   = {shift_ff[6:0], sync2_ff[`BCS_SI_MOSI]};

    // Read data, built from live synchronised levels and the stored indicator and PHY reset bits
    always_comb begin
        case (in_byte[6:0])
            `BCS_ADDR_GPI_HIGH:  rd_data = sync2_ff[`BCS_SI_GPI_HI:`BCS_SI_GPI_LO];  // RL1
            `BCS_ADDR_INDICATOR: rd_data = ind_ff;
            `BCS_ADDR_MGMT:      rd_data = {3'h0, sync2_ff[`BCS_SI_BOOT_DONE],           // RL8 RL15
                                            sync2_ff[`BCS_SI_WARM_REQ],                  // RL7
                                            sync2_ff[`BCS_SI_POR_REQ],                   // RL6
                                            sync2_ff[`BCS_SI_HOST_RST],                  // RL5
                                            sync2_ff[`BCS_SI_CHASSIS]};                  // RL4
            `BCS_ADDR_PHY:       rd_data = {6'h00, phy_ff[`BCS_PHY_RESET_BIT],
                                            sync2_ff[`BCS_SI_PHY_INTERRUPT_N]};                  // RL9 RL15
            `BCS_ADDR_BUTTON:    rd_data = {4'h0, sync2_ff[`BCS_SI_TEST_RST],            // RL14
                                            sync2_ff[`BCS_SI_BUTTON_A],                  // RL13
                                            sync2_ff[`BCS_SI_WARM_BTN],                  // RL12
                                            sync2_ff[`BCS_SI_FULL_BTN]};                 // RL11
            default:             rd_data = `BCS_ZERO_BYTE;
        endcase
    end

    // Serial port: command byte (bit 7 set = read, low 7 bits = offset), then data byte
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shift_ff    <= `BCS_ZERO_BYTE;
            cmd_ff      <= `BCS_ZERO_BYTE;
            tx_ff       <= `BCS_ZERO_BYTE;
            bit_cnt_ff  <= '0;
            wr_stb_ff   <= 1'b0;
            wr_addr_ff  <= '0;
            wr_data_ff  <= `BCS_ZERO_BYTE;
            spi_miso_ff <= 1'b0;
        end else begin
            wr_stb_ff <= 1'b0;
            if (!cs_act) begin
                bit_cnt_ff  <= '0;
                spi_miso_ff <= 1'b0;
            end else if (sclk_rise && bit_cnt_ff != `BCS_FRAME_BITS) begin
                shift_ff   <= in_byte;
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
                if (bit_cnt_ff == `BCS_CMD_LAST_BIT) begin
                    cmd_ff <= in_byte;
                    tx_ff  <= rd_data;
                end
                if (bit_cnt_ff == `BCS_DATA_LAST_BIT && !cmd_ff[`BCS_CMD_READ_BIT]) begin
                    wr_stb_ff  <= 1'b1;
                    wr_addr_ff <= cmd_ff[6:0];
                    wr_data_ff <= in_byte;
                end
            end else if (sclk_fall && bit_cnt_ff > `BCS_CMD_LAST_BIT
                         && bit_cnt_ff != `BCS_FRAME_BITS && cmd_ff[`BCS_CMD_READ_BIT]) begin
                spi_miso_ff <= tx_ff[7];
                tx_ff       <= {tx_ff[6:0], 1'b0};
            end
        end
    end

    // Indicator register, all eight bits stored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ind_ff <= `BCS_IND_RESET;  // RL3
        end else if (wr_stb_ff && wr_addr_ff == `BCS_ADDR_INDICATOR) begin
            ind_ff <= wr_data_ff;  // RL2
        end
    end

    // PHY control: only the reset bit is stored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phy_ff <= `BCS_PHY_RESET;  // RL10
        end else if (wr_stb_ff && wr_addr_ff == `BCS_ADDR_PHY) begin
            phy_ff[`BCS_PHY_RESET_BIT] <= wr_data_ff[`BCS_PHY_RESET_BIT];  // RL10 RL15
        end
    end

    // Level forwarding to the management controller
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mgmt_rst_ff  <= 1'b0;
            mgmt_boot_ff <= 1'b0;
        end else begin
            mgmt_rst_ff  <= sync2_ff[`BCS_SI_HOST_RST];   // RL5
            mgmt_boot_ff <= sync2_ff[`BCS_SI_BOOT_DONE];  // RL8
        end
    end

    // Reset requests; button_a is deliberately not a trigger
    assign full_trig = (sync2_ff[`BCS_SI_FULL_BTN] & ~prev_ff[`BCS_SI_FULL_BTN])      // RL11
                     | (~sync2_ff[`BCS_SI_POR_REQ] & prev_ff[`BCS_SI_POR_REQ]);       // RL6
    assign warm_trig = (sync2_ff[`BCS_SI_WARM_BTN] & ~prev_ff[`BCS_SI_WARM_BTN])      // RL12
                     | (~sync2_ff[`BCS_SI_WARM_REQ] & prev_ff[`BCS_SI_WARM_REQ]);     // RL7

    // Sequencer: wait the fixed delay, then hold the chosen reset low for the pulse time
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            seq_ff     <= BCS_SEQ_IDLE;
            kind_ff    <= BCS_KIND_FULL;
            seq_cnt_ff <= '0;
        end else begin
            case (seq_ff)
                BCS_SEQ_IDLE: begin
                    seq_cnt_ff <= '0;
                    if (full_trig) begin
                        seq_ff  <= BCS_SEQ_WAIT;
                        kind_ff <= BCS_KIND_FULL;
                    end else if (warm_trig) begin
                        seq_ff  <= BCS_SEQ_WAIT;
                        kind_ff <= BCS_KIND_WARM;
                    end
                end
                BCS_SEQ_WAIT: begin
                    if (seq_cnt_ff == 16'(SEQ_DELAY_CYC - 1)) begin
                        seq_ff     <= BCS_SEQ_ASSERT;  // RL11 RL12
                        seq_cnt_ff <= '0;
                    end else begin
                        seq_cnt_ff <= seq_cnt_ff + 16'h0001;
                    end
                end
                BCS_SEQ_ASSERT: begin
                    if (seq_cnt_ff == 16'(SEQ_PULSE_CYC - 1)) begin
                        seq_ff     <= BCS_SEQ_IDLE;
                        seq_cnt_ff <= '0;
                    end else begin
                        seq_cnt_ff <= seq_cnt_ff + 16'h0001;
                    end
                end
                default: begin
                    seq_ff     <= BCS_SEQ_IDLE;
                    seq_cnt_ff <= '0;
                end
            endcase
        end
    end

    // Reset outputs follow the sequencer one cycle later
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            full_n_ff <= 1'b1;
            warm_n_ff <= 1'b1;
        end else begin
            full_n_ff <= !(seq_ff == BCS_SEQ_ASSERT && kind_ff == BCS_KIND_FULL);  // RL11
            warm_n_ff <= !(seq_ff == BCS_SEQ_ASSERT && kind_ff == BCS_KIND_WARM);  // RL12
        end
    end

    // Cycles since reset release, for checks on pipelined inputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            up_cnt_ff <= '0;
        end else if (up_cnt_ff != `BCS_UP_SETTLED) begin
            up_cnt_ff <= up_cnt_ff + 3'h1;
        end
    end

    assign spi_miso                = spi_miso_ff;
    assign debug_indicator_out     = ind_ff[`BCS_IND_WIDTH-1:0];  // RL2
    assign phy_reset_out           = phy_ff[`BCS_PHY_RESET_BIT];  // RL10
    assign mgmt_reset_status_out_n = mgmt_rst_ff;
    assign mgmt_boot_complete_out  = mgmt_boot_ff;
    assign host_full_reset_n       = full_n_ff;
    assign host_warm_reset_n       = warm_n_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_gpi_read_live: assert property ( // RL1
        (cs_act && sclk_rise && bit_cnt_ff == `BCS_CMD_LAST_BIT && in_byte[6:0] == `BCS_ADDR_GPI_HIGH)
        |=> tx_ff == $past(sync2_ff[`BCS_SI_GPI_HI:`BCS_SI_GPI_LO]))
        else $error("gpi high byte not loaded from live inputs");

    chk_ro_write_ignored: assert property ( // RL15
        (wr_stb_ff && wr_addr_ff != `BCS_ADDR_INDICATOR)
        |=> $stable(ind_ff) && phy_ff[`BCS_PHY_RESET_BIT-1] == 1'b1 && phy_ff[7:2] == 6'h00)
        else $error("write to read-only offset changed state");

    chk_ind_write_drive: assert property ( // RL2
        (wr_stb_ff && wr_addr_ff == `BCS_ADDR_INDICATOR)
        |=> debug_indicator_out == $past(wr_data_ff[`BCS_IND_WIDTH-1:0]))
        else $error("indicator outputs do not follow write");

    chk_ind_reset_lit: assert property ( // RL3
        $rose(rst_b) |-> debug_indicator_out == 4'h0 && phy_reset_out == 1'b1)
        else $error("outputs not at reset value after reset");

    chk_rst_stat_fwd: assert property ( // RL5
        (up_cnt_ff == `BCS_UP_SETTLED) |-> mgmt_reset_status_out_n == $past(host_reset_status, 3))
        else $error("reset status not forwarded");

    chk_boot_done_fwd: assert property ( // RL8
        (up_cnt_ff == `BCS_UP_SETTLED) |-> mgmt_boot_complete_out == $past(host_boot_done, 3))
        else $error("boot complete not forwarded");

    chk_phy_write_drive: assert property ( // RL10
        (wr_stb_ff && wr_addr_ff == `BCS_ADDR_PHY)
        |=> phy_reset_out == $past(wr_data_ff[`BCS_PHY_RESET_BIT]))
        else $error("phy reset output does not follow write");

    chk_por_starts_full: assert property ( // RL6
        (seq_ff == BCS_SEQ_IDLE && $fell(sync2_ff[`BCS_SI_POR_REQ]))
        |=> seq_ff == BCS_SEQ_WAIT && kind_ff == BCS_KIND_FULL)
        else $error("power-on request did not start full sequence");

    chk_full_delay: assert property ( // RL11
        $fell(host_full_reset_n) |-> $past(seq_cnt_ff, 2) == 16'(SEQ_DELAY_CYC - 1)
                                   && $past(kind_ff) == BCS_KIND_FULL)
        else $error("full reset asserted before delay elapsed");

    chk_warm_delay: assert property ( // RL12
        $fell(host_warm_reset_n) |-> $past(seq_cnt_ff, 2) == 16'(SEQ_DELAY_CYC - 1)
                                   && $past(kind_ff) == BCS_KIND_WARM)
        else $error("warm reset asserted before delay elapsed");

    chk_button_a_inert: assert property ( // RL13
        (seq_ff == BCS_SEQ_IDLE && !full_trig && !warm_trig) |=> seq_ff == BCS_SEQ_IDLE)
        else $error("sequence started without a trigger");

    chk_mgmt_read_live: assert property ( // RL4
        (cs_act && sclk_rise && bit_cnt_ff == `BCS_CMD_LAST_BIT && in_byte[6:0] == `BCS_ADDR_MGMT)
        |=> tx_ff == {3'h0, $past(sync2_ff[`BCS_SI_BOOT_DONE:`BCS_SI_CHASSIS])})
        else $error("management status not loaded from live inputs");

    chk_phy_read_live: assert property ( // RL9
        (cs_act && sclk_rise && bit_cnt_ff == `BCS_CMD_LAST_BIT && in_byte[6:0] == `BCS_ADDR_PHY)
        |=> tx_ff == {6'h00, $past(phy_ff[`BCS_PHY_RESET_BIT]), $past(sync2_ff[`BCS_SI_PHY_INTERRUPT_N])})
        else $error("phy control read value wrong");

    chk_button_read_live: assert property ( // RL14
        (cs_act && sclk_rise && bit_cnt_ff == `BCS_CMD_LAST_BIT && in_byte[6:0] == `BCS_ADDR_BUTTON)
        |=> tx_ff == {4'h0, $past(sync2_ff[`BCS_SI_TEST_RST:`BCS_SI_FULL_BTN])})
        else $error("button status not loaded from live inputs");

    chk_warm_req_starts: assert property ( // RL7
        (seq_ff == BCS_SEQ_IDLE && $fell(sync2_ff[`BCS_SI_WARM_REQ]) && !full_trig)
        |=> seq_ff == BCS_SEQ_WAIT && kind_ff == BCS_KIND_WARM)
        else $error("warm request did not start warm sequence");

    chk_one_reset_kind: assert property ( // RL11
        !(host_full_reset_n == 1'b0 && host_warm_reset_n == 1'b0))
        else $error("full and warm reset asserted together");

    cov_write_indicator: cover property (wr_stb_ff && wr_addr_ff == `BCS_ADDR_INDICATOR);
    cov_read_frame:      cover property (sclk_fall && cmd_ff[`BCS_CMD_READ_BIT] && bit_cnt_ff > `BCS_CMD_LAST_BIT);
    cov_full_pulse:      cover property ($rose(host_full_reset_n));
    cov_warm_pulse:      cover property ($rose(host_warm_reset_n));
    cov_button_a_idle:   cover property ($rose(sync2_ff[`BCS_SI_BUTTON_A]) && seq_ff == BCS_SEQ_IDLE);

endmodule : bcs_regs

// *** dv/bcs_host_model.sv ***
// Host serial port model: sends mode 0 frames and collects read data
`timescale 1ns/1ps
module bcs_host_model (
    // Clock
    input  wire logic clk,
    // Serial port
    output logic      spi_clk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    localparam int HALF_CYC = 4;

    initial begin
        spi_clk  = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // Command byte then data byte, MSB first; read data taken at the end of each high phase
    task automatic frame(input logic [7:0] cmd, input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] word;
        logic [15:0] got;
        word = {cmd, wdata};
        got  = 16'h0000;
        @(posedge clk);
        spi_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi <= word[i];
            spi_clk  <= 1'b0;
            repeat (HALF_CYC) @(posedge clk);
            spi_clk <= 1'b1;
            repeat (HALF_CYC) @(posedge clk);
            got = {got[14:0], spi_miso};
        end
        spi_clk <= 1'b0;
        repeat (HALF_CYC) @(posedge clk);
        spi_cs_n <= 1'b1;
        // Released data line shows the inverse of its last level
        spi_mosi <= ~word[0];
        repeat (HALF_CYC) @(posedge clk);
        rdata = got[7:0];
    endtask : frame
endmodule : bcs_host_model

// *** dv/tb.sv ***
// Self-checking bench for the board control and status registers
`timescale 1ns/1ps
`include "bcs_cfg.svh"
module tb;
    localparam int DLY = 8;
    localparam int PLS = 4;
    logic       clk;
    logic       rst_b;
    logic       spi_clk;
    logic       spi_cs_n;
    logic       spi_mosi;
    logic       spi_miso;
    logic [7:0] host_gpi_high;
    logic       host_reset_status;
    logic       host_boot_done;
    logic       host_full_reset_n;
    logic       host_warm_reset_n;
    logic       mgmt_chassis_detect_n;
    logic       mgmt_power_on_request_n;
    logic       mgmt_warm_reset_request_n;
    logic       mgmt_reset_status_out_n;
    logic       mgmt_boot_complete_out;
    logic       phy_interrupt_n;
    logic       phy_reset_out;
    logic       full_reset_button;
    logic       warm_reset_button;
    logic       button_a;
    logic       test_port_reset_n;
    logic [3:0] debug_indicator_out;
    logic [7:0] seed;
    logic [7:0] v;
    logic [7:0] ind_q[$];
    int         ind_m;
    int         err_total;
    int         check_count;

    bcs_regs #(.SEQ_DELAY_CYC(DLY), .SEQ_PULSE_CYC(PLS)) dut (
        .clk(clk), .rst_b(rst_b), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .host_gpi_high(host_gpi_high), .host_reset_status(host_reset_status),
        .host_boot_done(host_boot_done), .host_full_reset_n(host_full_reset_n),
        .host_warm_reset_n(host_warm_reset_n), .mgmt_chassis_detect_n(mgmt_chassis_detect_n),
        .mgmt_power_on_request_n(mgmt_power_on_request_n),
        .mgmt_warm_reset_request_n(mgmt_warm_reset_request_n),
        .mgmt_reset_status_out_n(mgmt_reset_status_out_n), .mgmt_boot_complete_out(mgmt_boot_complete_out),
        .phy_interrupt_n(phy_interrupt_n), .phy_reset_out(phy_reset_out),
        .full_reset_button(full_reset_button), .warm_reset_button(warm_reset_button), .button_a(button_a),
        .test_port_reset_n(test_port_reset_n), .debug_indicator_out(debug_indicator_out)
    );

    bcs_host_model host (
        .clk(clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic rd(input logic [6:0] addr, output logic [7:0] val);
        host.frame({1'b1, addr}, 8'h00, val);
    endtask : rd

    task automatic wr(input logic [6:0] addr, input logic [7:0] val);
        logic [7:0] unused;
        host.frame({1'b0, addr}, val, unused);
    endtask : wr

    task automatic results();
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // Drive one trigger pin or button_a to its active level with random status levels, count reset pulse cycles, then read status back
    task automatic trig(input int which, input logic fire_full, input logic fire_warm);
        int low_full;
        int low_warm;
        int early;
        logic [7:0] r;
        low_full = 0;
        low_warm = 0;
        early    = 0;
        seed = lfsr_next(seed);
        @(posedge clk);
        {test_port_reset_n, mgmt_chassis_detect_n, host_reset_status, host_boot_done} <= seed[3:0];
        case (which)
            0: full_reset_button <= 1'b1;
            1: warm_reset_button <= 1'b1;
            2: mgmt_power_on_request_n <= 1'b0;
            3: mgmt_warm_reset_request_n <= 1'b0;
            default: button_a <= 1'b1;
        endcase
        for (int c = 0; c < DLY + PLS + 30; c++) begin
            @(posedge clk);
            low_full += (host_full_reset_n === 1'b0);
            low_warm += (host_warm_reset_n === 1'b0);
            early += (c < DLY) && (host_full_reset_n !== 1'b1 || host_warm_reset_n !== 1'b1);
        end
        check(8'(early), 8'h00, "pulse too early");
        check(8'(low_full), fire_full ? 8'(PLS) : 8'h00, "full pulse");
        check(8'(low_warm), fire_warm ? 8'(PLS) : 8'h00, "warm pulse");
        check({7'h00, mgmt_reset_status_out_n}, {7'h00, host_reset_status}, "status fwd");
        check({7'h00, mgmt_boot_complete_out}, {7'h00, host_boot_done}, "boot fwd");
        rd(`BCS_ADDR_BUTTON, r);
        check({4'h0, r[3:0]}, {4'h0, test_port_reset_n, button_a, warm_reset_button, full_reset_button}, "btn");
        rd(`BCS_ADDR_MGMT, r);
        check(r, {3'b000, host_boot_done, mgmt_warm_reset_request_n, mgmt_power_on_request_n,
                  host_reset_status, mgmt_chassis_detect_n}, "mgmt status");
        @(posedge clk);
        {full_reset_button, warm_reset_button, button_a} <= 3'b000;
        {mgmt_power_on_request_n, mgmt_warm_reset_request_n} <= 2'b11;
        repeat (10) @(posedge clk);
    endtask : trig

    initial begin
        err_total   = 0;
        check_count = 0;
        seed        = 8'h5d;
        rst_b <= 1'b0;
        host_gpi_high <= 8'h00;
        {host_reset_status, host_boot_done, mgmt_chassis_detect_n, phy_interrupt_n} <= 4'h0;
        {mgmt_power_on_request_n, mgmt_warm_reset_request_n, test_port_reset_n} <= 3'b111;
        {full_reset_button, warm_reset_button, button_a} <= 3'b000;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        check({4'h0, debug_indicator_out}, 8'h00, "ind after reset");
        check({7'h00, phy_reset_out}, 8'h01, "phy after reset");
        rd(`BCS_ADDR_INDICATOR, v);
        check(v, 8'h00, "ind reset read");
        rd(`BCS_ADDR_PHY, v);
        check(v, {6'h00, 1'b1, phy_interrupt_n}, "phy reset read");
        for (int i = 0; i < 3; i++) begin
            seed = lfsr_next(seed);
            @(posedge clk);
            host_gpi_high <= seed;
            wr(`BCS_ADDR_GPI_HIGH, ~seed);
            rd(`BCS_ADDR_GPI_HIGH, v);
            check(v, seed, "gpi high");
        end
        ind_q = '{8'h0f, 8'ha5, 8'hf0};
        seed = lfsr_next(seed);
        ind_q.push_back(seed);
        foreach (ind_q[i]) begin
            ind_m = int'(ind_q[i]);
            wr(`BCS_ADDR_INDICATOR, ind_q[i]);
            check({4'h0, debug_indicator_out}, {4'h0, 4'(ind_m)}, "ind out");
            rd(`BCS_ADDR_INDICATOR, v);
            check(v, 8'(ind_m), "ind read");
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            phy_interrupt_n <= i[0];
            wr(`BCS_ADDR_PHY, i[0] ? 8'h02 : 8'hfd);
            check({7'h00, phy_reset_out}, {7'h00, i[0]}, "phy out");
            rd(`BCS_ADDR_PHY, v);
            check(v, {6'h00, i[0], i[0]}, "phy read");
        end
        rd(7'h7f, v);
        check(v, 8'h00, "unmapped read");
        wr(`BCS_ADDR_MGMT, 8'hff);
        wr(`BCS_ADDR_BUTTON, 8'hff);
        for (int w = 0; w < 5; w++) begin
            trig(w, w == 0 || w == 2, w == 1 || w == 3);
        end
        results();
    end

    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
endmodule : tb
